/* rtl/uiifc_ctrl.sv */
// What this block does
// - identity bits 7:6 always read 11, fixed
// - id field resets to 0001; line error pending gives 0110, top priority
// - line status read clears pending line status interrupt
// - data available gives 0100; cleared by buffer read or level below trigger
// - four idle char times with data gives 1100; buffer read clears
// - holding empty gives 0010; cleared by identity read showing 0010 or holding write
// - modem change gives 0000, lowest; cleared by modem status read
// - identity writes ignored; bits 5:4 read zero
// - trigger field codes 00..11 select 1,4,8,14 bytes; 14 after reset
// - tx flush bit discards tx fifo and its count, shifter kept
// - rx flush bit discards rx fifo and its count, shifter kept
module uiifc_ctrl
    import uiifc_pkg::*;
#(
    parameter int LEVEL_W = 5
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire uiifc_cond_type cond_i,
    input wire uiifc_strobe_type strobe_i,
    input wire logic [LEVEL_W-1:0] rx_level_i,
    output logic tx_flush_o,
    output logic rx_flush_o,
    output logic dma_ready_signal_enable_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    function automatic logic [4:0] trig_bytes(input logic [1:0] code);
        unique case (code)
            2'h0: trig_bytes = TRIG_L0;
            2'h1: trig_bytes = TRIG_L1;
            2'h2: trig_bytes = TRIG_L2;
            2'h3: trig_bytes = TRIG_L3;
        endcase
    endfunction : trig_bytes

    // ------------------------------------------------------------
    // bus decode: one wait state, answer on second cycle
    // ------------------------------------------------------------
    logic busy;
    logic acc_rd;
    logic acc_wr;
    logic [1:0] receive_trigger_level;
    logic dma_en;
    logic [3:0] cur_id;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] pend;
    logic [LEVEL_W-1:0] lvl;
    logic [4:0] trig;
    logic at_trig;

    // reads are taken on the first edge so data stands when wait drops
    assign acc_rd = avs_read_i && !busy;
    assign acc_wr = avs_write_i && busy && avs_byteenable_i[0];
    assign lvl = rx_level_i;
    assign trig = trig_bytes(receive_trigger_level);
    assign at_trig = 5'(lvl) >= trig;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end else begin
            busy <= (avs_read_i || avs_write_i) && !busy;
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !busy);
        end
    end

    // ------------------------------------------------------------
    // fifo setup
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            receive_trigger_level <= TRIG_RESET;
            dma_en <= DMA_EN_RESET;
            tx_flush_o <= 1'b0;
            rx_flush_o <= 1'b0;
        end else begin
            tx_flush_o <= 1'b0;
            rx_flush_o <= 1'b0;
            if (acc_wr && avs_address_i == OFS_FIFO_SETUP) begin
                receive_trigger_level <= avs_writedata_i[TRIG_HI:TRIG_LO];
                dma_en <= avs_writedata_i[DMA_EN_BIT];
                tx_flush_o <= avs_writedata_i[TX_FLUSH_BIT];
                rx_flush_o <= avs_writedata_i[RX_FLUSH_BIT];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            dma_ready_signal_enable_o <= DMA_EN_RESET;
        end else begin
            dma_ready_signal_enable_o <= dma_en;
        end
    end

    // ------------------------------------------------------------
    // character timeout
    // ------------------------------------------------------------
    logic [2:0] idle_chars;
    logic tmo_set;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            idle_chars <= 3'h0;
        end else if (strobe_i.rbr_rd || lvl == '0 || rx_flush_o) begin
            idle_chars <= 3'h0;
        end else if (cond_i.char_tick && idle_chars != 3'(CHAR_TIMES)) begin
            idle_chars <= idle_chars + 3'h1;
        end
    end
    assign tmo_set = cond_i.char_tick && lvl != '0 && !strobe_i.rbr_rd
        && idle_chars == 3'(CHAR_TIMES - 1);

    // ------------------------------------------------------------
    // pending interrupt sources
    // ------------------------------------------------------------
    logic id_rd;
    logic thre_d;
    assign id_rd = acc_rd && avs_address_i == OFS_INTERRUPT_IDENTITY;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend <= '0;
            thre_d <= 1'b0;
        end else begin
            thre_d <= cond_i.thr_empty;
            // line status: set wins over the read clear
            if (cond_i.line_err) begin
                pend[EV_LINE] <= 1'b1;
            end else if (strobe_i.lsr_rd) begin
                pend[EV_LINE] <= 1'b0;
            end
            pend[EV_RXDATA] <= at_trig && !strobe_i.rbr_rd;
            if (tmo_set) begin
                pend[EV_TIMEOUT] <= 1'b1;
            end else if (strobe_i.rbr_rd || lvl == '0) begin
                pend[EV_TIMEOUT] <= 1'b0;
            end
            if (cond_i.thr_empty && !thre_d) begin
                pend[EV_THRE] <= 1'b1;
            end else if ((id_rd && cur_id == ID_THRE) || strobe_i.thr_wr) begin
                pend[EV_THRE] <= 1'b0;
            end
            if (cond_i.modem_chg) begin
                pend[EV_MODEM] <= 1'b1;
            end else if (strobe_i.msr_rd) begin
                pend[EV_MODEM] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // priority encoder, gated by mask
    // ------------------------------------------------------------
    logic [EV_W-1:0] live;
    logic [3:0] next_id;
    assign live = pend & mask;

    always_comb begin
        next_id = ID_NONE;
        if (live[EV_LINE]) begin
            next_id = ID_LINE;
        end else if (live[EV_RXDATA]) begin
            next_id = ID_RXDATA;
        end else if (live[EV_TIMEOUT]) begin
            next_id = ID_TIMEOUT;
        end else if (live[EV_THRE]) begin
            next_id = ID_THRE;
        end else if (live[EV_MODEM]) begin
            next_id = ID_MODEM;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cur_id <= ID_RESET;
        end else begin
            cur_id <= next_id;
        end
    end

    // ------------------------------------------------------------
    // sticky event status, mask, interrupt
    // ------------------------------------------------------------
    logic st_wr;
    logic [EV_W-1:0] rise;
    logic [EV_W-1:0] pend_d;
    assign st_wr = acc_wr && avs_address_i == OFS_EVENT_STATUS;
    assign rise = pend & ~pend_d;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_d <= '0;
            status <= '0;
        end else begin
            pend_d <= pend;
            status <= (status & ~(st_wr ? avs_writedata_i[EV_W-1:0] : '0))
                | rise;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            mask <= '0;
        end else if (acc_wr && avs_address_i == OFS_EVENT_MASK) begin
            mask <= avs_writedata_i[EV_W-1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status & mask);
        end
    end

    // ------------------------------------------------------------
    // read data; identity writes fall through unmapped
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_o <= '0;
        end else if (acc_rd) begin
            unique case (avs_address_i)
                OFS_INTERRUPT_IDENTITY:
                    avs_readdata_o <= {24'h0, MODE_FIFO_ON, 2'h0, cur_id};
                OFS_EVENT_STATUS: avs_readdata_o <= 32'(status);
                OFS_EVENT_MASK: avs_readdata_o <= 32'(mask);
                OFS_FIFO_LEVELS:
                    avs_readdata_o <= {16'h0, 3'h0, trig, 3'h0, 5'(lvl)};
                default: avs_readdata_o <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_mode_bits;
        @(posedge mclk_i) disable iff (!rst_n)
        (acc_rd && avs_address_i == OFS_INTERRUPT_IDENTITY) |=>
            avs_readdata_o[7:4] == 4'hC;
    endproperty
    a_mode_bits: assert property (p_mode_bits)
        else $error("mode bits bad");

    property p_line_top;
        @(posedge mclk_i) disable iff (!rst_n)
        live[EV_LINE] |=> cur_id == ID_LINE;
    endproperty
    a_line_top: assert property (p_line_top) else $error("line not top");

    property p_line_clr;
        @(posedge mclk_i) disable iff (!rst_n)
        (strobe_i.lsr_rd && !cond_i.line_err) |=> !pend[EV_LINE];
    endproperty
    a_line_clr: assert property (p_line_clr)
        else $error("line not cleared");

    property p_rxdata;
        @(posedge mclk_i) disable iff (!rst_n)
        (at_trig && !strobe_i.rbr_rd) |=> pend[EV_RXDATA];
    endproperty
    a_rxdata: assert property (p_rxdata) else $error("rx data lost");

    property p_tmo_clr;
        @(posedge mclk_i) disable iff (!rst_n)
        (strobe_i.rbr_rd && !tmo_set) |=> !pend[EV_TIMEOUT];
    endproperty
    a_tmo_clr: assert property (p_tmo_clr) else $error("timeout stuck");

    property p_thre_clr;
        @(posedge mclk_i) disable iff (!rst_n)
        (strobe_i.thr_wr && !(cond_i.thr_empty && !thre_d)) |=>
            !pend[EV_THRE];
    endproperty
    a_thre_clr: assert property (p_thre_clr) else $error("thre stuck");

    property p_modem_id;
        @(posedge mclk_i) disable iff (!rst_n)
        (live == (EV_W'(1) << EV_MODEM)) |=> cur_id == ID_MODEM;
    endproperty
    a_modem_id: assert property (p_modem_id) else $error("modem id");

    property p_flush;
        @(posedge mclk_i) disable iff (!rst_n)
        (acc_wr && avs_address_i == OFS_FIFO_SETUP) |=>
            rx_flush_o == $past(avs_writedata_i[RX_FLUSH_BIT]) ##1 !rx_flush_o;
    endproperty
    a_flush: assert property (p_flush) else $error("rx flush");

    property p_tmo_set;
        @(posedge mclk_i) disable iff (!rst_n)
        tmo_set |=> pend[EV_TIMEOUT];
    endproperty
    a_tmo_set: assert property (p_tmo_set)
        else $error("timeout lost");

    property p_rxdata_clr;
        @(posedge mclk_i) disable iff (!rst_n)
        !at_trig |=> !pend[EV_RXDATA];
    endproperty
    a_rxdata_clr: assert property (p_rxdata_clr)
        else $error("rx data stuck");

    property p_thre_id;
        @(posedge mclk_i) disable iff (!rst_n)
        (id_rd && cur_id == ID_THRE && !(cond_i.thr_empty && !thre_d)) |=>
            !pend[EV_THRE];
    endproperty
    a_thre_id: assert property (p_thre_id)
        else $error("thre not cleared by identity read");

    property p_trig_sel;
        @(posedge mclk_i) disable iff (!rst_n)
        (acc_wr && avs_address_i == OFS_FIFO_SETUP
            && avs_writedata_i[TRIG_HI:TRIG_LO] == 2'h0) |=> trig == TRIG_L0;
    endproperty
    a_trig_sel: assert property (p_trig_sel)
        else $error("trigger level select");

endmodule : uiifc_ctrl

/* pkg/uiifc_pkg.sv */
package uiifc_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_INTERRUPT_IDENTITY = 5'h08;
    localparam logic [4:0] OFS_FIFO_SETUP = 5'h0C;
    localparam logic [4:0] OFS_EVENT_STATUS = 5'h10;
    localparam logic [4:0] OFS_EVENT_MASK = 5'h14;
    localparam logic [4:0] OFS_FIFO_LEVELS = 5'h18;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int TRIG_HI = 7;
    localparam int TRIG_LO = 6;
    localparam int DMA_EN_BIT = 3;
    localparam int TX_FLUSH_BIT = 2;
    localparam int RX_FLUSH_BIT = 1;
    localparam logic [1:0] MODE_FIFO_ON = 2'h3;
    localparam logic [3:0] ID_RESET = 4'h1;
    localparam logic [1:0] TRIG_RESET = 2'h3;
    localparam logic DMA_EN_RESET = 1'b1;

    // ------------------------------------------------------------
    // identification codes
    // ------------------------------------------------------------
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_LINE = 4'h6;
    localparam logic [3:0] ID_RXDATA = 4'h4;
    localparam logic [3:0] ID_TIMEOUT = 4'hC;
    localparam logic [3:0] ID_THRE = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;

    // trigger levels for codes 00..11
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0E;

    // event bits in status/mask
    localparam int EV_LINE = 0;
    localparam int EV_RXDATA = 1;
    localparam int EV_TIMEOUT = 2;
    localparam int EV_THRE = 3;
    localparam int EV_MODEM = 4;
    localparam int EV_W = 5;

    // four character times
    localparam int CHAR_TIMES = 4;

    typedef struct packed {
        logic line_err;
        logic thr_empty;
        logic modem_chg;
        logic char_tick;
    } uiifc_cond_type;

    typedef struct packed {
        logic lsr_rd;
        logic rbr_rd;
        logic thr_wr;
        logic msr_rd;
    } uiifc_strobe_type;

endpackage : uiifc_pkg

/* verification/uiifc_partner.sv */
module uiifc_partner
    import uiifc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rx_flush_i,
    output uiifc_cond_type cond_o,
    output uiifc_strobe_type strobe_o,
    output logic [4:0] rx_level_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cond_o = '0;
        strobe_o = '0;
        rx_level_o = 5'h00;
    end

    // ----------------------------------------------------------
    // receive fifo
    // ----------------------------------------------------------
    always @(posedge mclk_i) begin
        if (rx_flush_i) begin
            rx_level_o <= 5'h00;
        end
    end

    task automatic set_level(input logic [4:0] v);
        @(posedge mclk_i);
        rx_level_o <= v;
    endtask : set_level

    // ----------------------------------------------------------
    // events and strobes
    // ----------------------------------------------------------
    task automatic set_thr(input logic v);
        @(posedge mclk_i);
        cond_o.thr_empty <= v;
    endtask : set_thr

    // a holding write fills the holding register again
    task automatic pulse(input uiifc_cond_type c, input uiifc_strobe_type s);
        @(posedge mclk_i);
        cond_o.line_err <= c.line_err;
        cond_o.modem_chg <= c.modem_chg;
        cond_o.char_tick <= c.char_tick;
        strobe_o <= s;
        if (s.thr_wr) begin
            cond_o.thr_empty <= 1'b0;
        end
        @(posedge mclk_i);
        cond_o.line_err <= 1'b0;
        cond_o.modem_chg <= 1'b0;
        cond_o.char_tick <= 1'b0;
        strobe_o <= '0;
    endtask : pulse
endmodule : uiifc_partner

/* verification/uiifc_ctrl_tb.sv */
module uiifc_ctrl_tb
    import uiifc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    uiifc_cond_type cond_i;
    uiifc_strobe_type strobe_i;
    logic [4:0] rx_level_i;
    logic tx_flush_o;
    logic rx_flush_o;
    logic dma_ready_signal_enable_o;
    logic irq_o;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_txf = 0;
    int n_rxf = 0;
    logic [31:0] rd;
    localparam uiifc_cond_type LINE = 4'h8;
    localparam uiifc_cond_type MODEM = 4'h2;
    localparam uiifc_cond_type TICK = 4'h1;
    localparam uiifc_strobe_type LSR = 4'h8;
    localparam uiifc_strobe_type RECEIVE_BUFFER = 4'h4;
    localparam uiifc_strobe_type TRANSMIT_HOLDING = 4'h2;
    localparam uiifc_strobe_type MSR = 4'h1;

    always #2 mclk_i = ~mclk_i;

    uiifc_ctrl i_uiifc_ctrl (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .cond_i(cond_i),
        .strobe_i(strobe_i),
        .rx_level_i(rx_level_i),
        .tx_flush_o(tx_flush_o),
        .rx_flush_o(rx_flush_o),
        .dma_ready_signal_enable_o(dma_ready_signal_enable_o),
        .irq_o(irq_o)
    );

    uiifc_partner i_uiifc_partner (
        .mclk_i(mclk_i),
        .rx_flush_i(rx_flush_o),
        .cond_o(cond_i),
        .strobe_o(strobe_i),
        .rx_level_o(rx_level_i)
    );

    always @(posedge mclk_i) begin
        cyc++;
        n_txf += int'(tx_flush_o === 1'b1);
        n_rxf += int'(rx_flush_o === 1'b1);
        if (cyc == 6000) begin
            n_errors++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= ~w;
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : acc

    task automatic idc(input logic [3:0] e);
        acc(1'b0, OFS_INTERRUPT_IDENTITY, 32'h0);
        chk(rd, {24'h0, MODE_FIFO_ON, 2'h0, e});
    endtask : idc

    task automatic ev(input uiifc_cond_type c, input uiifc_strobe_type s);
        i_uiifc_partner.pulse(c, s);
        repeat (5) @(posedge mclk_i);
    endtask : ev

    task automatic end_of_test;
        $display("n_errors=%0d tests_run=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        idc(ID_RESET);
        acc(1'b0, OFS_FIFO_LEVELS, 32'h0);
        chk(rd & 32'h1F00, {19'h0, TRIG_L3, 8'h0});
        chk(32'(dma_ready_signal_enable_o), 32'h1);
        acc(1'b1, OFS_INTERRUPT_IDENTITY, 32'hFFFF_FFFF);
        idc(ID_RESET);
        acc(1'b0, 5'h1C, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset

    task automatic t_irq;
        ev(LINE, '0);
        chk(32'(irq_o), 32'h0);
        acc(1'b1, OFS_EVENT_MASK, 32'h1F);
        repeat (5) @(posedge mclk_i);
        chk(32'(irq_o), 32'h1);
        idc(ID_LINE);
        ev('0, LSR);
        idc(ID_NONE);
        acc(1'b1, OFS_EVENT_STATUS, 32'h1F);
        repeat (5) @(posedge mclk_i);
        chk(32'(irq_o), 32'h0);
    endtask : t_irq

    task automatic t_prio;
        i_uiifc_partner.set_thr(1'b1);
        ev(LINE | MODEM, '0);
        idc(ID_LINE);
        ev('0, LSR);
        idc(ID_THRE);
        repeat (3) @(posedge mclk_i);
        idc(ID_MODEM);
        ev('0, MSR);
        idc(ID_NONE);
        acc(1'b1, OFS_EVENT_STATUS, 32'h1F);
        // a fresh empty edge so the holding write has something to clear
        i_uiifc_partner.set_thr(1'b0);
        i_uiifc_partner.set_thr(1'b1);
        repeat (5) @(posedge mclk_i);
        chk(32'(irq_o), 32'h1);
        ev('0, TRANSMIT_HOLDING);
        idc(ID_NONE);
        acc(1'b0, OFS_EVENT_STATUS, 32'h0);
        chk(rd & 32'h8, 32'h8);
    endtask : t_prio

    task automatic t_trig;
        logic [4:0] lv[4];
        lv = '{TRIG_L0, TRIG_L1, TRIG_L2, TRIG_L3};
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, OFS_FIFO_SETUP, {24'h0, 2'(i), 6'h08});
            i_uiifc_partner.set_level(lv[i] - 5'h01);
            repeat (5) @(posedge mclk_i);
            idc(ID_NONE);
            i_uiifc_partner.set_level(lv[i]);
            repeat (5) @(posedge mclk_i);
            idc(ID_RXDATA);
            acc(1'b0, OFS_FIFO_LEVELS, 32'h0);
            chk(rd & 32'h1F00, {19'h0, lv[i], 8'h0});
            i_uiifc_partner.set_level(lv[i] - 5'h01);
            repeat (5) @(posedge mclk_i);
            idc(ID_NONE);
        end
    endtask : t_trig

    task automatic t_tmo;
        acc(1'b1, OFS_FIFO_SETUP, 32'h48);
        i_uiifc_partner.set_level(5'h01);
        repeat (3) ev(TICK, '0);
        idc(ID_NONE);
        ev(TICK, '0);
        idc(ID_TIMEOUT);
        ev('0, RECEIVE_BUFFER);
        idc(ID_NONE);
    endtask : t_tmo

    task automatic t_flush;
        i_uiifc_partner.set_level(5'h03);
        n_txf = 0;
        n_rxf = 0;
        acc(1'b1, OFS_FIFO_SETUP, 32'h0E);
        repeat (5) @(posedge mclk_i);
        chk(n_txf, 1);
        chk(n_rxf, 1);
        chk(32'(rx_level_i), 32'h0);
        acc(1'b1, OFS_FIFO_SETUP, 32'h08);
        repeat (5) @(posedge mclk_i);
        chk(n_txf + n_rxf, 2);
        chk(32'(dma_ready_signal_enable_o), 32'h1);
    endtask : t_flush

    initial begin
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        t_reset();
        t_irq();
        t_prio();
        t_trig();
        t_tmo();
        t_flush();
        end_of_test();
    end
endmodule : uiifc_ctrl_tb
